/* File: shared/madc_pkg.sv */
// constants, types and register map for the four-channel converter sequencer
// assumes both ends and the controller registers run on pclk at 10 MHz
package madc_pkg;
  localparam int NUM_ADC  = 4;
  localparam int DATA_W   = 8;
  localparam int APB_AW   = 8;
  localparam int PCLK_NS  = 100;

  // converter clock divider: 2-bit count, clock is count bit 1
  localparam int          DIV_RATIO = 4;
  localparam logic [1:0]  DIV_RISE  = 2'h1;
  localparam logic [1:0]  DIV_FALL  = 2'h3;

  localparam logic [DATA_W-1:0] SAR_INIT = 8'h80;
  localparam logic [3:0]        EOC_EDGE = 4'h9;

  localparam int T_START_NS    = 640;
  localparam int START_LO_CYC  = (T_START_NS + PCLK_NS - 1) / PCLK_NS;
  localparam int EOC_WAIT_CYC  = 35;
  localparam int DELAY_CYC     = EOC_WAIT_CYC + DIV_RATIO;
  localparam int READ_LAT      = 2;
  localparam int CNT_W         = 6;

  localparam logic [APB_AW-1:0] OFS_CTRL     = 8'h00;
  localparam logic [APB_AW-1:0] OFS_CMD      = 8'h04;
  localparam logic [APB_AW-1:0] OFS_STAT     = 8'h08;
  localparam logic [APB_AW-1:0] OFS_IRQ_STAT = 8'h0c;
  localparam logic [APB_AW-1:0] OFS_IRQ_MASK = 8'h10;
  localparam logic [APB_AW-1:0] OFS_RES_BASE = 8'h20;

  localparam int CTRL_MODE_LSB = 4;
  localparam int CMD_GO        = 0;
  localparam int STAT_BUSY     = 0;
  localparam int STAT_DONE_LSB = 4;
  localparam int IRQ_DONE      = 0;
  localparam int IRQ_REFUSED   = 1;
  localparam int IRQ_W         = 2;

  typedef enum logic [1:0] {
    MADC_POLL  = 2'h0,
    MADC_DELAY = 2'h1,
    MADC_IRQ   = 2'h2
  } madc_mode_t;

  typedef enum logic [4:0] {
    MADC_IDLE = 5'h01,
    MADC_LOW  = 5'h02,
    MADC_WAIT = 5'h04,
    MADC_SCAN = 5'h08,
    MADC_READ = 5'h10
  } madc_state_t;
endpackage

/* File: shared/madc_if.sv */
// link between the controller's port bits and the converter array
// the shared data bus and the wired-OR done line are resolved here
`timescale 1ns/1ps
interface madc_if;
  import madc_pkg::*;
  logic [NUM_ADC-1:0]             start_n;
  logic [NUM_ADC-1:0]             out_en;
  logic [NUM_ADC-1:0]             conv_done;
  logic [NUM_ADC-1:0][DATA_W-1:0] drv_data;
  logic [NUM_ADC-1:0]             drv_oe_n;
  logic [DATA_W-1:0]              bus_data;
  logic                           done_any;

  // bus carries the or of all enabled drivers; floats to zero when none drives
  always_comb begin
    bus_data = '0;
    for (int i = 0; i < NUM_ADC; i++) begin
      if (!drv_oe_n[i]) begin
        bus_data = bus_data | drv_data[i];
      end
    end
  end

  assign done_any = |conv_done;

  modport dev (input start_n, input out_en, output conv_done, output drv_data, output drv_oe_n);
  modport ctl (output start_n, output out_en, input conv_done, input done_any, input bus_data);
endinterface

/* File: logic/madc_conv_array.sv */
// converter end: clock divider, trigger flip-flops, successive approximation, bus drivers
// assumes vin is a digital stand-in for each analogue input, steady during a conversion
`timescale 1ns/1ps
module madc_conv_array (
  input  wire logic                                       pclk,
  input  wire logic                                       presetn,
  madc_if.dev                                             lnk,
  input  wire logic [madc_pkg::NUM_ADC-1:0][madc_pkg::DATA_W-1:0] vin,
  output logic                                            conv_clk
);
  import madc_pkg::*;

  logic [1:0]                     div_cnt;
  logic                           rise_en;
  logic                           fall_en;
  logic [NUM_ADC-1:0]             trig;
  logic [NUM_ADC-1:0][DATA_W-1:0] result;
  logic [NUM_ADC-1:0][3:0]        edge_cnt;

  ////////////////////////////////////////////////////////////////////////
  // converter clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= 2'h0;
    end else begin
      div_cnt <= div_cnt + 2'h1;
    end
  end

  assign rise_en = (div_cnt == DIV_RISE);
  assign fall_en = (div_cnt == DIV_FALL);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_clk <= 1'b0;
    end else begin
      conv_clk <= rise_en ? 1'b1 : (fall_en ? 1'b0 : conv_clk);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // trigger flip-flops: clear forces low, next rising edge sets high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig <= '1;
    end else begin
      for (int i = 0; i < NUM_ADC; i++) begin
        if (!lnk.start_n[i]) begin
          trig[i] <= 1'b0;
        end else if (rise_en) begin
          trig[i] <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // successive approximation, one decision per falling edge for eight edges, done raised on the ninth
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result   <= '0;
      edge_cnt <= '0;
      lnk.conv_done <= '0;
    end else begin
      for (int i = 0; i < NUM_ADC; i++) begin
        if (!trig[i]) begin
          result[i]        <= SAR_INIT;
          edge_cnt[i]      <= 4'h0;
          lnk.conv_done[i] <= 1'b0;
        end else if (fall_en && !lnk.conv_done[i]) begin
          edge_cnt[i] <= edge_cnt[i] + 4'h1;
          if (edge_cnt[i] == EOC_EDGE - 4'h1) begin
            lnk.conv_done[i] <= 1'b1;
          end else begin
            if (vin[i] < result[i]) begin
              result[i][3'(DATA_W - 1) - edge_cnt[i][2:0]] <= 1'b0;
            end
            if (edge_cnt[i] != 4'(DATA_W - 1)) begin
              result[i][3'(DATA_W - 2) - edge_cnt[i][2:0]] <= 1'b1;
            end
          end
        end
      end
    end
  end
  // result stays untouched once done until trig falls again

  ////////////////////////////////////////////////////////////////////////
  // three-state drivers onto the shared bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lnk.drv_oe_n <= '1;
      lnk.drv_data <= '0;
    end else begin
      for (int i = 0; i < NUM_ADC; i++) begin
        lnk.drv_oe_n[i] <= !lnk.out_en[i];
        lnk.drv_data[i] <= lnk.out_en[i] ? result[i] : '0;
      end
    end
  end
endmodule

/* File: logic/madc_sequencer.sv */
// controller end: apb registers, start pulses, done detection, one-at-a-time readout
// assumes an apb master on pclk and the converter array across madc_if
`timescale 1ns/1ps
module madc_sequencer (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [madc_pkg::APB_AW-1:0]   paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  output logic                               irq,
  madc_if.ctl                                lnk
);
  import madc_pkg::*;

  logic [NUM_ADC-1:0]             ctrl_sel;
  madc_mode_t                     ctrl_mode;
  logic [IRQ_W-1:0]               irq_stat;
  logic [IRQ_W-1:0]               irq_mask;
  logic [NUM_ADC-1:0][DATA_W-1:0] results;
  madc_state_t                    state;
  logic [CNT_W-1:0]               cnt;
  logic [NUM_ADC-1:0]             run_sel;
  logic [2:0]                     ch;
  logic [1:0]                     wptr;
  logic                           wr;
  logic                           go_req;
  logic                           go_ok;
  logic                           wait_over;
  logic                           ev_done;
  logic                           ev_refused;
  logic                           res_hit;
  logic [1:0]                     res_idx;
  logic [31:0]                    next_rdata;
  logic                           next_err;

  ////////////////////////////////////////////////////////////////////////
  // apb access decode
  assign wr       = psel && penable && pready && pwrite;
  assign go_req   = wr && (paddr == OFS_CMD) && pwdata[CMD_GO];
  assign go_ok    = go_req && (state == MADC_IDLE) && (ctrl_sel != '0);
  assign res_idx  = paddr[3:2];
  assign res_hit  = (paddr[APB_AW-1:4] == OFS_RES_BASE[APB_AW-1:4]) && (paddr[1:0] == 2'h0)
                    && (32'(res_idx) < 32'(NUM_ADC));

  always_comb begin
    next_rdata = '0;
    next_err   = 1'b0;
    if (res_hit) begin
      next_rdata[DATA_W-1:0] = results[res_idx];
    end else begin
      case (paddr)
        OFS_CTRL: begin
          next_rdata[NUM_ADC-1:0]                 = ctrl_sel;
          next_rdata[CTRL_MODE_LSB+1:CTRL_MODE_LSB] = ctrl_mode;
        end
        OFS_CMD: begin
          next_rdata = '0;
        end
        OFS_STAT: begin
          next_rdata[STAT_BUSY]                                = (state != MADC_IDLE);
          next_rdata[STAT_DONE_LSB+NUM_ADC-1:STAT_DONE_LSB]   = lnk.conv_done & 4'hf;
        end
        OFS_IRQ_STAT: begin
          next_rdata[IRQ_W-1:0] = irq_stat;
        end
        OFS_IRQ_MASK: begin
          next_rdata[IRQ_W-1:0] = irq_mask;
        end
        default: begin
          next_err = 1'b1;
        end
      endcase
    end
  end

  // no wait state: answer registered during the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      prdata  <= (psel && !penable && !pwrite) ? next_rdata : '0;
      pslverr <= psel && !penable && next_err;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control and mask registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_sel  <= '0;
      ctrl_mode <= MADC_POLL;
      irq_mask  <= '0;
    end else if (wr) begin
      if (paddr == OFS_CTRL) begin
        ctrl_sel  <= pwdata[NUM_ADC-1:0];
        ctrl_mode <= madc_mode_t'(pwdata[CTRL_MODE_LSB+1:CTRL_MODE_LSB]);
      end
      if (paddr == OFS_IRQ_MASK) begin
        irq_mask <= pwdata[IRQ_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sticky events, write one to clear, a new event wins
  assign ev_refused = go_req && !go_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= '0;
    end else begin
      irq_stat <= (irq_stat & ~((wr && paddr == OFS_IRQ_STAT) ? pwdata[IRQ_W-1:0] : '0))
                  | {ev_refused, ev_done};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat & irq_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // conversion sequence
  always_comb begin
    case (ctrl_mode)
      MADC_DELAY: wait_over = (cnt == '0);
      MADC_IRQ:   wait_over = lnk.done_any;
      default:    wait_over = ((lnk.conv_done & run_sel) == run_sel);
    endcase
  end

  assign ev_done = (state == MADC_SCAN) && (32'(ch) == 32'(NUM_ADC));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state   <= MADC_IDLE;
      cnt     <= '0;
      run_sel <= '0;
      ch      <= 3'h0;
      wptr    <= 2'h0;
    end else begin
      case (state)
        MADC_IDLE: begin
          if (go_ok) begin
            run_sel <= ctrl_sel;
            cnt     <= CNT_W'(START_LO_CYC - 1);
            state   <= MADC_LOW;
          end
        end
        MADC_LOW: begin
          if (cnt == '0) begin
            cnt   <= CNT_W'(DELAY_CYC - 1);
            state <= MADC_WAIT;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        MADC_WAIT: begin
          if (cnt != '0) begin
            cnt <= cnt - 1'b1;
          end
          if (wait_over) begin
            ch    <= 3'h0;
            wptr  <= 2'h0;
            state <= MADC_SCAN;
          end
        end
        MADC_SCAN: begin
          if (32'(ch) == 32'(NUM_ADC)) begin
            state <= MADC_IDLE;
          end else if (run_sel[ch[1:0]]) begin
            cnt   <= CNT_W'(READ_LAT - 1);
            state <= MADC_READ;
          end else begin
            ch <= ch + 3'h1;
          end
        end
        MADC_READ: begin
          if (cnt == '0) begin
            ch    <= ch + 3'h1;
            wptr  <= wptr + 2'h1;
            state <= MADC_SCAN;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        default: begin
          state <= MADC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      results <= '0;
    end else if (state == MADC_READ && cnt == '0) begin
      results[wptr] <= lnk.bus_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // port bits toward the converters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lnk.start_n <= '1;
    end else if (go_ok) begin
      lnk.start_n <= ~ctrl_sel;
    end else if (state == MADC_LOW && cnt == '0) begin
      lnk.start_n <= '1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lnk.out_en <= '0;
    end else if (state == MADC_SCAN && 32'(ch) != 32'(NUM_ADC) && run_sel[ch[1:0]]) begin
      lnk.out_en <= NUM_ADC'(1) << ch[1:0];
    end else if (state != MADC_READ) begin
      lnk.out_en <= '0;
    end
  end
endmodule

/* File: testbench/madc_properties.sv */
// concurrent checks on the link between sequencer and converter array
// assumes the signals of one madc_if instance, all timed by pclk
`timescale 1ns/1ps
module madc_properties (
  input wire logic                                                 pclk,
  input wire logic                                                 presetn,
  input wire logic [madc_pkg::NUM_ADC-1:0]                         start_n,
  input wire logic [madc_pkg::NUM_ADC-1:0]                         out_en,
  input wire logic [madc_pkg::NUM_ADC-1:0]                         conv_done,
  input wire logic [madc_pkg::NUM_ADC-1:0][madc_pkg::DATA_W-1:0]   drv_data,
  input wire logic [madc_pkg::NUM_ADC-1:0]                         drv_oe_n
);
  import madc_pkg::*;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////
  property p_one_en;
    $onehot0(out_en);
  endproperty
  a_one_en: assert property (p_one_en) else $error("two output enables high");
  property p_one_drv;
    $onehot0(~drv_oe_n);
  endproperty
  a_one_drv: assert property (p_one_drv) else $error("two drivers on data bus");
  property p_oe_off;
    (out_en == 4'h0) [*2] |-> drv_oe_n == 4'hf;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("driver on without enable");
  property p_oe_cause;
    !drv_oe_n[0] |-> $past(out_en[0]);
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("channel 0 drives unrequested");
  property p_start_w;
    $fell(start_n[0]) |-> (!start_n[0]) [*7];
  endproperty
  a_start_w: assert property (p_start_w) else $error("start pulse too short");
  property p_clear;
    (!start_n[0]) [*3] |-> !conv_done[0];
  endproperty
  a_clear: assert property (p_clear) else $error("done kept during start");
  property p_done_t;
    $rose(start_n[0]) |-> (!conv_done[0]) [*8] ##[24:32] conv_done[0];
  endproperty
  a_done_t: assert property (p_done_t) else $error("done outside its window");
  property p_hold;
    (start_n[0] && conv_done[0]) ##1 start_n[0] |-> conv_done[0];
  endproperty
  a_hold: assert property (p_hold) else $error("done dropped without start");
  property p_keep;
    !drv_oe_n[0] ##1 !drv_oe_n[0] |-> $stable(drv_data[0]);
  endproperty
  a_keep: assert property (p_keep) else $error("result changed while read");
  property p_rst;
    !$past(presetn) |-> start_n == 4'hf && out_en == 4'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("port bits wrong after reset");
  property p_read_done;
    out_en != 4'h0 |-> (out_en & conv_done) != 4'h0;
  endproperty
  a_read_done: assert property (p_read_done) else $error("read before done");
endmodule

/* File: testbench/tb_top.sv */
// self-checking bench: apb tasks drive the sequencer, converter array on the far side
// assumes madc_pkg, madc_if, both design modules and the checker are compiled first
`timescale 1ns/1ps
module tb_top;
  import madc_pkg::*;
  logic                            pclk;
  logic                            presetn;
  logic                            psel;
  logic                            penable;
  logic                            pwrite;
  logic [APB_AW-1:0]               paddr;
  logic [31:0]                     pwdata;
  logic [31:0]                     prdata;
  logic                            pready;
  logic                            pslverr;
  logic                            irq;
  logic                            conv_clk;
  logic [NUM_ADC-1:0][DATA_W-1:0]  vin;
  logic [31:0]                     rd;
  logic                            err;
  logic [31:0]                     ctl_tab [4] = '{32'h0f, 32'h15, 32'h2f, 32'h33};
  logic [1:0]                      msk_tab [4] = '{2'h1, 2'h3, 2'h0, 2'h1};
  time                             t0;
  int                              k;
  int                              n_errors = 0;
  int                              check_count = 0;
  int                              cycles = 0;
  madc_if lnk ();
  madc_sequencer madc_sequencer_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .lnk(lnk));
  madc_conv_array madc_conv_array_i (.pclk(pclk), .presetn(presetn), .lnk(lnk), .vin(vin),
    .conv_clk(conv_clk));
  madc_properties madc_properties_i (.pclk(pclk), .presetn(presetn), .start_n(lnk.start_n),
    .out_en(lnk.out_en), .conv_done(lnk.conv_done), .drv_data(lnk.drv_data), .drv_oe_n(lnk.drv_oe_n));
  ////////////////////////////////////////////////////////////
  always #50 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      stop_test();
    end
  end
  task stop_test();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer; read data and error taken at the edge that sees pready
  task apb(input logic wr, input logic [APB_AW-1:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // polls the sticky done bit, checks the interrupt level, then clears
  task wait_done(input logic exp_irq);
    rd = '0;
    for (int n = 0; n < 100 && rd[IRQ_DONE] !== 1'b1; n++) begin
      apb(1'b0, OFS_IRQ_STAT, '0);
    end
    check(32'(rd[IRQ_DONE]), 32'h1);
    @(posedge pclk);
    check(32'(irq), 32'(exp_irq));
    apb(1'b1, OFS_IRQ_STAT, 32'h3);
    repeat (2) @(posedge pclk);
    check(32'(irq), 32'h0);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    vin = {8'h7f, 8'h80, 8'hff, 8'h00};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check(32'(lnk.start_n), 32'hf);
    check(32'(lnk.out_en), 32'h0);
    for (int i = 0; i < 9; i++) begin
      apb(1'b0, 8'(4 * i), '0);
      check(rd, '0);
    end
    apb(1'b0, 8'h40, '0);
    check(32'(err), 32'h1);
    @(posedge conv_clk);
    t0 = $time;
    @(posedge conv_clk);
    check(32'($time - t0), 32'h190);
    // poll, delay, shared done and spare mode, each with fresh inputs
    for (int r = 0; r < 4; r++) begin
      vin <= ~{vin[2:0], vin[3]};
      apb(1'b1, OFS_IRQ_MASK, 32'(msk_tab[r]));
      apb(1'b1, OFS_CTRL, ctl_tab[r]);
      apb(1'b1, OFS_CMD, 32'h1);
      wait_done(msk_tab[r][IRQ_DONE]);
      k = 0;
      for (int i = 0; i < NUM_ADC; i++) begin
        if (ctl_tab[r][i]) begin
          apb(1'b0, OFS_RES_BASE + 8'(4 * k), '0);
          check(rd, 32'(vin[i]));
          k++;
        end
      end
    end
    // go with no channel, then go while busy
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b1, OFS_CMD, 32'h1);
    apb(1'b0, OFS_IRQ_STAT, '0);
    check(rd, 32'h2);
    apb(1'b1, OFS_CTRL, 32'h1);
    apb(1'b1, OFS_CMD, 32'h1);
    apb(1'b1, OFS_IRQ_STAT, 32'h2);
    apb(1'b1, OFS_CMD, 32'h1);
    apb(1'b0, OFS_STAT, '0);
    check(32'(rd[STAT_BUSY]), 32'h1);
    apb(1'b0, OFS_IRQ_STAT, '0);
    check(32'(rd[IRQ_REFUSED]), 32'h1);
    wait_done(1'b1);
    // reset in the middle of a conversion
    apb(1'b1, OFS_CMD, 32'h1);
    repeat (3) @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    check(32'(lnk.start_n), 32'hf);
    presetn <= 1'b1;
    apb(1'b0, OFS_RES_BASE, '0);
    check(rd, '0);
    stop_test();
  end
endmodule
